//--- hdl/bdcr_top.sv
// bdcr_top: i2c register bank and dimming-mode engine of a six-string backlight driver
//
// Notes on behaviour
// [RULE1] three-bit dimming mode field, resets to mixed fixed-rate
// [RULE2] one bit picks 12.5 or 25 percent threshold
// [RULE3] direct pwm: strings follow input level
// [RULE4] direct pwm: output repeats at input frequency
// [RULE5] dc mode: amplitude updates two periods later
// [RULE6] host leaves unassigned register bits untouched
// [RULE7] i2c target address 0111100
// [RULE8] mode, boost frequency, full-scale current writable
// [RULE9] mixed: above threshold amplitude, below quarter-current pwm
// [RULE10] mixed: response two input periods late
// [RULE11] fast-mode i2c, address auto-increments per byte
// [RULE12] measure on internal clock, hold until done
`timescale 1ns/10ps
module bdcr_top import bdcr_pkg::*; #(
    parameter int unsigned IDLE_TIMEOUT = IDLE_TIMEOUT_CYC // no-edge limit
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_i, // i2c clock pin
    input wire logic sda_i, // i2c data pin level
    output logic sda_o, // i2c data drive value, always low
    output logic sda_oe_n, // low while pulling sda low
    input wire logic pwm_i, // brightness pwm input pin
    output logic [5:0] string_enable, // per-string current sink on
    output logic [11:0] string_level, // amplitude, fraction of full scale
    output bdcr_pkg::bdcr_cfg_s cfg // register fields for the analog side
);
    import bdcr_pkg::*;

    bdcr_state_s s_ff; // registered state
    bdcr_state_s nxt_s; // next state

    // true for offsets that hold a register
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a < 8'(NUM_LOW_REGS)) || (a == OFS_NVM);
    endfunction : is_mapped

    // read mux; unmapped offsets read as zero
    function automatic logic [7:0] rd_reg(input bdcr_state_s s, input logic [7:0] a);
        rd_reg = 8'h00;
        if (a == OFS_NVM) begin
            rd_reg = s.nvm;
        end else if (is_mapped(a)) begin
            rd_reg = s.regs[a[3:0]];
        end
    endfunction : rd_reg

    // this cycle's events
    logic scl_rise; // filtered scl edges
    logic scl_fall;
    logic start_cond; // sda falls with scl high
    logic stop_cond; // sda rises with scl high
    logic pwm_rise; // filtered input rising edge
    logic [7:0] rd_byte; // byte under the pointer
    logic [11:0] thr; // mixed change threshold
    logic [21:0] fix_prod; // duty times regenerated period
    logic [13:0] duty_x4; // duty scaled for quarter current
    logic [11:0] fix_duty; // duty fed to the fixed-rate generator
    logic fix_on; // fixed-rate generator output
    logic [CNT_W:0] rem2; // divider trial remainder

    // next-state logic
    always_comb begin
        nxt_s = s_ff;
        // three-flop pin filter
        nxt_s.scl_sync = {s_ff.scl_sync[1:0], scl_i};
        nxt_s.sda_sync = {s_ff.sda_sync[1:0], sda_i};
        nxt_s.pwm_sync = {s_ff.pwm_sync[1:0], pwm_i};
        if (s_ff.scl_sync[2] == s_ff.scl_sync[1]) begin
            nxt_s.scl_f = s_ff.scl_sync[1];
        end
        if (s_ff.sda_sync[2] == s_ff.sda_sync[1]) begin
            nxt_s.sda_f = s_ff.sda_sync[1];
        end
        if (s_ff.pwm_sync[2] == s_ff.pwm_sync[1]) begin
            nxt_s.pwm_f = s_ff.pwm_sync[1];
        end
        scl_rise = nxt_s.scl_f & ~s_ff.scl_f;
        scl_fall = ~nxt_s.scl_f & s_ff.scl_f;
        start_cond = s_ff.scl_f & nxt_s.scl_f & s_ff.sda_f & ~nxt_s.sda_f;
        stop_cond = s_ff.scl_f & nxt_s.scl_f & ~s_ff.sda_f & nxt_s.sda_f;
        pwm_rise = nxt_s.pwm_f & ~s_ff.pwm_f;
        rd_byte = rd_reg(s_ff, s_ff.ptr);

        // i2c target; start and stop override any state
        if (start_cond) begin
            nxt_s.st = ST_ADDR;
            nxt_s.bitcnt = 4'h0;
            nxt_s.drive = 1'b0;
        end else if (stop_cond) begin
            nxt_s.st = ST_IDLE;
            nxt_s.drive = 1'b0;
        end else if (scl_rise) begin
            // host bits sampled on scl rise
            case (s_ff.st)
                ST_ADDR, ST_REG, ST_WDATA: begin
                    nxt_s.shreg = {s_ff.shreg[6:0], s_ff.sda_f};
                    nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
                end
                ST_RDATA: begin
                    nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
                end
                ST_RACK: begin
                    nxt_s.nack = s_ff.sda_f; // high: host is done
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            // drive changes while scl low
            case (s_ff.st)
                ST_ADDR: begin
                    if (s_ff.bitcnt == 4'h8) begin
                        nxt_s.bitcnt = 4'h0;
                        if (s_ff.shreg[7:1] == I2C_ADDR) begin // RULE7
                            nxt_s.rw = s_ff.shreg[0];
                            nxt_s.drive = 1'b1;
                            nxt_s.st = ST_ACK_ADDR;
                        end else begin
                            nxt_s.st = ST_IDLE; // another target: stay off the bus
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    nxt_s.bitcnt = 4'h0;
                    if (s_ff.rw) begin
                        // read starts at the last pointer
                        nxt_s.shreg = rd_byte;
                        nxt_s.drive = ~rd_byte[7];
                        nxt_s.st = ST_RDATA;
                    end else begin
                        nxt_s.drive = 1'b0;
                        nxt_s.st = ST_REG;
                    end
                end
                ST_REG: begin
                    if (s_ff.bitcnt == 4'h8) begin
                        nxt_s.ptr = s_ff.shreg; // RULE11
                        nxt_s.bitcnt = 4'h0;
                        nxt_s.drive = 1'b1;
                        nxt_s.st = ST_ACK_REG;
                    end
                end
                ST_ACK_REG: begin
                    nxt_s.drive = 1'b0;
                    nxt_s.st = ST_WDATA;
                end
                ST_WDATA: begin
                    if (s_ff.bitcnt == 4'h8) begin
                        // unmapped offsets: acked, dropped
                        if (s_ff.ptr == OFS_NVM) begin
                            nxt_s.nvm = s_ff.shreg;
                        end else if (is_mapped(s_ff.ptr)) begin
                            nxt_s.regs[s_ff.ptr[3:0]] = s_ff.shreg; // RULE8
                        end
                        nxt_s.bitcnt = 4'h0;
                        nxt_s.drive = 1'b1;
                        nxt_s.st = ST_ACK_W;
                    end
                end
                ST_ACK_W: begin
                    nxt_s.drive = 1'b0;
                    nxt_s.ptr = s_ff.ptr + 8'h01; // RULE11
                    nxt_s.st = ST_WDATA;
                end
                ST_RDATA: begin
                    if (s_ff.bitcnt == 4'h8) begin
                        nxt_s.drive = 1'b0; // release for the master's ack
                        nxt_s.ptr = s_ff.ptr + 8'h01; // RULE11
                        nxt_s.st = ST_RACK;
                    end else begin
                        nxt_s.shreg = {s_ff.shreg[6:0], 1'b0};
                        nxt_s.drive = ~s_ff.shreg[6];
                    end
                end
                ST_RACK: begin
                    nxt_s.bitcnt = 4'h0;
                    if (s_ff.nack) begin
                        nxt_s.st = ST_IDLE;
                    end else begin
                        nxt_s.shreg = rd_byte;
                        nxt_s.drive = ~rd_byte[7];
                        nxt_s.st = ST_RDATA;
                    end
                end
                default: begin
                    nxt_s.st = ST_IDLE;
                end
            endcase
        end

        // period and high time on internal clock
        nxt_s.per_cnt = s_ff.per_cnt + CNT_W'(1); // RULE12
        if (s_ff.pwm_f) begin
            nxt_s.high_cnt = s_ff.high_cnt + CNT_W'(1);
        end
        if (pwm_rise) begin
            // apply the result of the period before last
            if (s_ff.pending_ok) begin
                nxt_s.applied = s_ff.pending; // RULE5 RULE10
            end
            nxt_s.pending_ok = 1'b0;
            // a finished period starts the division
            if (s_ff.meas_ok) begin
                nxt_s.div_per = s_ff.per_cnt;
                nxt_s.rem = {1'b0, s_ff.high_cnt};
                nxt_s.quot = 12'h000;
                nxt_s.div_step = 4'h0;
                nxt_s.div_busy = 1'b1;
            end
            nxt_s.meas_ok = 1'b1;
            nxt_s.per_cnt = CNT_W'(1);
            nxt_s.high_cnt = CNT_W'(0);
        end else if (s_ff.per_cnt >= CNT_W'(IDLE_TIMEOUT)) begin
            // no edge: input is a steady level
            nxt_s.applied = s_ff.pwm_f ? DUTY_FULL : DUTY_ZERO;
            nxt_s.per_cnt = s_ff.per_cnt;
            nxt_s.high_cnt = CNT_W'(0);
            nxt_s.meas_ok = 1'b0;
            nxt_s.pending_ok = 1'b0;
            nxt_s.div_busy = 1'b0;
        end

        // restoring divider, one quotient bit per cycle
        rem2 = {s_ff.rem[CNT_W-1:0], 1'b0};
        if (s_ff.div_busy && !pwm_rise) begin
            if (rem2 >= {1'b0, s_ff.div_per}) begin
                nxt_s.rem = rem2 - {1'b0, s_ff.div_per};
                nxt_s.quot = {s_ff.quot[10:0], 1'b1};
            end else begin
                nxt_s.rem = rem2;
                nxt_s.quot = {s_ff.quot[10:0], 1'b0};
            end
            nxt_s.div_step = s_ff.div_step + 4'h1;
            if (s_ff.div_step == DIV_STEPS - 4'h1) begin
                nxt_s.div_busy = 1'b0;
                nxt_s.pending_ok = 1'b1;
                // a period that is high throughout clamps to full
                nxt_s.pending = (s_ff.rem[CNT_W-1:0] >= s_ff.div_per) ? DUTY_FULL
                    : nxt_s.quot;
            end
        end

        // free-running fixed-rate generator
        if (s_ff.fix_cnt == FIX_CW'(FIX_CYC - 1)) begin
            nxt_s.fix_cnt = '0;
        end else begin
            nxt_s.fix_cnt = s_ff.fix_cnt + FIX_CW'(1);
        end
        thr = s_ff.regs[OFS_DIM_CTRL[3:0]][F_CHG_DUTY] ? THR_25 : THR_12P5; // RULE2
        // quarter current needs four times the on-time
        duty_x4 = {s_ff.applied, 2'b00};
        fix_duty = s_ff.applied;
        if (s_ff.regs[OFS_DIM_CTRL[3:0]][F_MODE_HI:F_MODE_LO] == MODE_MIXED_FIXED_RATE_DIMMING)
        begin
            fix_duty = (duty_x4[13:12] != 2'b00) ? DUTY_FULL : duty_x4[11:0];
        end
        fix_prod = {10'h000, fix_duty} * 22'(FIX_CYC);
        fix_on = (s_ff.fix_cnt < fix_prod[21:12]);

        // dimming mode decode
        case (s_ff.regs[OFS_DIM_CTRL[3:0]][F_MODE_HI:F_MODE_LO]) // RULE1
            MODE_DIRECT_PWM: begin
                // no resampling: sinks follow the input
                nxt_s.string_on = nxt_s.pwm_f; // RULE3 RULE4
                nxt_s.level = DUTY_FULL;
            end
            MODE_REGENERATED_FIXED_RATE_PWM: begin
                nxt_s.string_on = fix_on;
                nxt_s.level = DUTY_FULL;
            end
            MODE_MIXED: begin
                if (s_ff.applied >= thr) begin // RULE9
                    nxt_s.string_on = 1'b1;
                    nxt_s.level = s_ff.applied;
                end else begin
                    nxt_s.string_on = nxt_s.pwm_f;
                    nxt_s.level = QUARTER_LEVEL;
                end
            end
            MODE_MIXED_FIXED_RATE_DIMMING: begin
                if (s_ff.applied >= thr) begin // RULE9
                    nxt_s.string_on = 1'b1;
                    nxt_s.level = s_ff.applied;
                end else begin
                    nxt_s.string_on = fix_on;
                    nxt_s.level = QUARTER_LEVEL;
                end
            end
            default: begin
                // dc and unused codes
                nxt_s.string_on = (s_ff.applied != DUTY_ZERO); // RULE5
                nxt_s.level = s_ff.applied;
            end
        endcase
    end

    // state register; reset loads defaults
    always_ff @(posedge clk) begin
        if (srst) begin
            s_ff <= '0;
            s_ff.scl_sync <= 3'h7; // idle bus is high
            s_ff.sda_sync <= 3'h7;
            s_ff.scl_f <= 1'b1;
            s_ff.sda_f <= 1'b1;
            s_ff.st <= ST_IDLE;
            s_ff.regs <= RST_LOW_REGS; // RULE1 RULE2
            s_ff.nvm <= RST_NVM;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from flops
    assign sda_o = 1'b0;
    assign sda_oe_n = ~s_ff.drive;
    assign string_enable = (s_ff.string_on && s_ff.regs[OFS_CH_EN[3:0]][F_BACKLIGHT_ENABLE])
        ? s_ff.regs[OFS_CH_EN[3:0]][F_CH_HI:F_CH_LO] : 6'h00;
    assign string_level = s_ff.level;
    assign cfg.dim_mode = s_ff.regs[OFS_DIM_CTRL[3:0]][F_MODE_HI:F_MODE_LO];
    assign cfg.change_duty_25 = s_ff.regs[OFS_DIM_CTRL[3:0]][F_CHG_DUTY];
    assign cfg.edge_rate = s_ff.regs[OFS_DIM_CTRL[3:0]][F_EDGE_HI:F_EDGE_LO];
    assign cfg.spread_spectrum = s_ff.regs[OFS_DIM_CTRL[3:0]][F_SPREAD];
    assign cfg.boost_freq = s_ff.regs[OFS_BOOST_FREQ[3:0]][F_FREQ_HI:F_FREQ_LO];
    assign cfg.current_limit_high = s_ff.regs[OFS_BOOST_FREQ[3:0]][F_ILIM];
    assign cfg.full_scale = s_ff.regs[OFS_FULL_SCALE[3:0]];
    assign cfg.nvm_ctrl = s_ff.nvm;
endmodule : bdcr_top

//--- shared/bdcr_pkg.sv
// bdcr_pkg: constants, field layouts and state types of the backlight dimming register bank
package bdcr_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ = 20_000_000; // internal oscillator rate
    localparam int unsigned FIXED_PWM_HZ = 26_000; // regenerated output pwm rate
    localparam int unsigned FIX_CYC = CLK_HZ / FIXED_PWM_HZ; // cycles per regenerated period
    localparam int unsigned FIX_CW = 10; // width of the regenerated period counter
    localparam int unsigned MIN_PWM_HZ = 100; // slowest input treated as a pwm wave
    localparam int unsigned IDLE_TIMEOUT_CYC = CLK_HZ / MIN_PWM_HZ; // no edge: input is a level
    localparam int unsigned CNT_W = 20; // width of period and high-time counters
    // i2c target address
    localparam logic [6:0] I2C_ADDR = 7'h3C;
    // register offsets
    localparam logic [7:0] OFS_DIM_CTRL = 8'h00;
    localparam logic [7:0] OFS_BOOST_FREQ = 8'h01;
    localparam logic [7:0] OFS_FULL_SCALE = 8'h02;
    localparam logic [7:0] OFS_CH_EN = 8'h0B;
    localparam logic [7:0] OFS_NVM = 8'hFF;
    localparam int unsigned NUM_LOW_REGS = 12; // offsets dimming_and_switching_control to channel_enables
    // reset values, dimming_and_switching_control .. channel_enables and nonvolatile_program_control
    localparam logic [7:0] RST_DIM_CTRL = 8'h6B;
    localparam logic [7:0] RST_BOOST_FREQ = 8'h17;
    localparam logic [7:0] RST_FULL_SCALE = 8'h82;
    localparam logic [7:0] RST_MAPPING = 8'h04;
    localparam logic [7:0] RST_BRIGHT_HI = 8'h00;
    localparam logic [7:0] RST_BRIGHT_LO = 8'h00;
    localparam logic [7:0] RST_FILTER = 8'hA8;
    localparam logic [7:0] RST_SAMPLE = 8'h00;
    localparam logic [7:0] RST_DIVISION = 8'h00;
    localparam logic [7:0] RST_LIGHT_LOAD = 8'h78;
    localparam logic [7:0] RST_PROTECT = 8'h1A;
    localparam logic [7:0] RST_CH_EN = 8'hFE;
    localparam logic [7:0] RST_NVM = 8'h00;
    localparam logic [NUM_LOW_REGS-1:0][7:0] RST_LOW_REGS = {RST_CH_EN, RST_PROTECT,
        RST_LIGHT_LOAD, RST_DIVISION, RST_SAMPLE, RST_FILTER, RST_BRIGHT_LO, RST_BRIGHT_HI,
        RST_MAPPING, RST_FULL_SCALE, RST_BOOST_FREQ, RST_DIM_CTRL};
    // field positions
    localparam int unsigned F_MODE_LO = 0;
    localparam int unsigned F_MODE_HI = 2;
    localparam int unsigned F_CHG_DUTY = 3;
    localparam int unsigned F_EDGE_LO = 5;
    localparam int unsigned F_EDGE_HI = 6;
    localparam int unsigned F_SPREAD = 7;
    localparam int unsigned F_FREQ_LO = 0;
    localparam int unsigned F_FREQ_HI = 3;
    localparam int unsigned F_ILIM = 4;
    localparam int unsigned F_CH_LO = 1;
    localparam int unsigned F_CH_HI = 6;
    localparam int unsigned F_BACKLIGHT_ENABLE = 7;
    // duty and amplitude scale, 4096 = 100 percent
    localparam int unsigned DUTY_W = 12;
    localparam logic [11:0] DUTY_FULL = 12'hFFF;
    localparam logic [11:0] DUTY_ZERO = 12'h000;
    localparam logic [11:0] THR_25 = 12'h400; // 25 percent
    localparam logic [11:0] THR_12P5 = 12'h200; // 12.5 percent
    localparam logic [11:0] QUARTER_LEVEL = 12'h400; // one quarter of full-scale current
    localparam logic [3:0] DIV_STEPS = 4'hC; // one quotient bit per step
    // dimming modes
    typedef enum logic [2:0] {
        MODE_DIRECT_PWM = 3'h0,
        MODE_REGENERATED_FIXED_RATE_PWM = 3'h1,
        MODE_MIXED = 3'h2,
        MODE_MIXED_FIXED_RATE_DIMMING = 3'h3,
        MODE_DC = 3'h4
    } bdcr_mode_e;
    // i2c target states, one-hot
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ACK_ADDR = 9'h004,
        ST_REG = 9'h008,
        ST_ACK_REG = 9'h010,
        ST_WDATA = 9'h020,
        ST_ACK_W = 9'h040,
        ST_RDATA = 9'h080,
        ST_RACK = 9'h100
    } bdcr_i2c_e;
    // configuration fields driven out to the analog side
    typedef struct packed {
        logic [2:0] dim_mode;
        logic change_duty_25;
        logic [1:0] edge_rate;
        logic spread_spectrum;
        logic [3:0] boost_freq;
        logic current_limit_high;
        logic [7:0] full_scale;
        logic [7:0] nvm_ctrl;
    } bdcr_cfg_s;
    // complete state of the block
    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic [2:0] pwm_sync;
        logic scl_f;
        logic sda_f;
        logic pwm_f;
        bdcr_i2c_e st;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic rw;
        logic nack;
        logic drive;
        logic [NUM_LOW_REGS-1:0][7:0] regs;
        logic [7:0] nvm;
        logic [CNT_W-1:0] per_cnt;
        logic [CNT_W-1:0] high_cnt;
        logic meas_ok;
        logic [CNT_W-1:0] div_per;
        logic [CNT_W:0] rem;
        logic [11:0] quot;
        logic [3:0] div_step;
        logic div_busy;
        logic [11:0] pending;
        logic pending_ok;
        logic [11:0] applied;
        logic [FIX_CW-1:0] fix_cnt;
        logic string_on;
        logic [11:0] level;
    } bdcr_state_s;
endpackage : bdcr_pkg

//--- dv/bdcr_i2c_host.sv
// bdcr_i2c_host: behavioural i2c host that programs the register bank
`timescale 1ns/10ps
module bdcr_i2c_host import bdcr_pkg::*; (
    input wire logic clk, // paces bus phases
    input wire logic sda_in, // resolved data wire
    output logic scl, // bus clock
    output logic sda_h // 0 pulls data low
);
    initial begin
        scl = 1'b1;
        sda_h = 1'b1;
    end
    // one bus phase
    task automatic ph();
        repeat (8) @(negedge clk);
    endtask : ph
    // data set while scl low, read at end of high
    task automatic bit_io(input logic b, output logic r);
        sda_h = b;
        ph();
        scl = 1'b1;
        ph();
        r = sda_in;
        scl = 1'b0;
        ph();
    endtask : bit_io
    // start: sda falls while scl high
    task automatic start();
        sda_h = 1'b1;
        ph();
        scl = 1'b1;
        ph();
        sda_h = 1'b0;
        ph();
        scl = 1'b0;
        ph();
    endtask : start
    task automatic stop();
        sda_h = 1'b0;
        ph();
        scl = 1'b1;
        ph();
        sda_h = 1'b1;
        ph();
    endtask : stop
    // byte msb first, then ack slot
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(a, ak);
    endtask : xfer
    // burst write; nak ors every ack
    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d[$],
                      output logic nak);
        logic [7:0] q;
        logic ak;
        start();
        xfer({dev, 1'b0}, 1'b1, q, nak);
        xfer(ptr, 1'b1, q, ak);
        nak = nak | ak;
        foreach (d[i]) begin
            xfer(d[i], 1'b1, q, ak);
            nak = nak | ak;
        end
        stop();
    endtask : wr
    // pointer write, repeated start, burst read
    task automatic rd(input logic [7:0] ptr, input int n, output logic [7:0] q[$]);
        logic [7:0] b;
        logic ak;
        q = {};
        start();
        xfer({I2C_ADDR, 1'b0}, 1'b1, b, ak);
        xfer(ptr, 1'b1, b, ak);
        start();
        xfer({I2C_ADDR, 1'b1}, 1'b1, b, ak);
        for (int i = 0; i < n; i++) begin
            xfer(8'hFF, i == n - 1, b, ak);
            q.push_back(b);
        end
        stop();
    endtask : rd
endmodule : bdcr_i2c_host

//--- dv/bdcr_checker.sv
// bdcr_checker: port-level checks of the dimming register bank
`timescale 1ns/10ps
module bdcr_checker import bdcr_pkg::*; #(
    parameter int unsigned IDLE_TIMEOUT = IDLE_TIMEOUT_CYC // no-edge limit
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic pwm_i,
    input wire logic [5:0] string_enable,
    input wire logic [11:0] string_level,
    input wire bdcr_pkg::bdcr_cfg_s cfg
);
    logic pwm_d_ff; // pwm pin one clock ago
    logic [31:0] since_rise_ff; // clocks since pwm pin rise
    // helper counters
    always_ff @(posedge clk) begin
        pwm_d_ff <= pwm_i;
        since_rise_ff <= (srst || (pwm_i && !pwm_d_ff)) ? 32'h0 : since_rise_ff + 32'h1;
    end
    sda_low_only_a: assert property (@(posedge clk) disable iff (srst) sda_o == 1'b0)
        else $error("sda drive value not low");
    reset_state_a: assert property (@(posedge clk) disable iff (srst)
        $fell(srst) |-> cfg.dim_mode == 3'h3 && cfg.change_duty_25 && sda_oe_n
            && string_enable == 6'h00) else $error("state after reset wrong");
    ack_scl_low_a: assert property (@(posedge clk) disable iff (srst)
        $fell(sda_oe_n) |-> !scl_i) else $error("sda pulled while scl high");
    direct_follow_a: assert property (@(posedge clk) disable iff (srst)
        cfg.dim_mode == 3'h0 && $past(cfg.dim_mode, 4) == 3'h0 && string_enable != 6'h00
            |-> $past(pwm_i, 4)) else $error("strings on while pwm input low");
    direct_off_a: assert property (@(posedge clk) disable iff (srst)
        cfg.dim_mode == 3'h0 && $fell(pwm_i) |-> ##5 (string_enable == 6'h00
            || cfg.dim_mode != 3'h0)) else $error("strings did not turn off with input");
    direct_full_a: assert property (@(posedge clk) disable iff (srst)
        cfg.dim_mode == 3'h0 && $past(cfg.dim_mode, 2) == 3'h0 |-> string_level == 12'hFFF)
        else $error("direct mode level not full");
    level_timing_a: assert property (@(posedge clk) disable iff (srst)
        cfg.dim_mode >= 3'h2 && $past(cfg.dim_mode, 2) == cfg.dim_mode
            && $past(cfg.change_duty_25, 2) == cfg.change_duty_25 && $changed(string_level)
            |-> since_rise_ff <= 12 || since_rise_ff >= IDLE_TIMEOUT)
        else $error("level changed away from an input rise");
    mixed_floor_a: assert property (@(posedge clk) disable iff (srst)
        cfg.dim_mode inside {3'h2, 3'h3} && string_enable != 6'h00
            && $past(cfg.dim_mode, 2) == cfg.dim_mode
            && $past(cfg.change_duty_25, 2) == cfg.change_duty_25
            |-> string_level >= (cfg.change_duty_25 ? 12'h400 : 12'h200))
        else $error("mixed level below threshold");
endmodule : bdcr_checker
bind bdcr_top bdcr_checker #(.IDLE_TIMEOUT(IDLE_TIMEOUT)) u_chk (.clk(clk), .srst(srst),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .pwm_i(pwm_i),
    .string_enable(string_enable), .string_level(string_level), .cfg(cfg));

//--- dv/bdcr_top_tb.sv
// bdcr_top_tb: register and dimming-mode tests driven through the i2c host model
`timescale 1ns/10ps
module bdcr_top_tb;
    import bdcr_pkg::*;
    localparam int unsigned TO = 2000; // short no-edge timeout
    localparam logic [7:0] EXP_RST [12] = '{8'h6B, 8'h17, 8'h82, 8'h04, 8'h00, 8'h00,
        8'hA8, 8'h00, 8'h00, 8'h78, 8'h1A, 8'hFE};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic pwm = 1'b0; // brightness input
    logic scl; // host
    logic sda_h; // host drive
    logic sda_o;
    logic sda_oe_n;
    logic [5:0] string_enable;
    logic [11:0] string_level;
    bdcr_cfg_s cfg;
    int miscompares = 0;
    int checks_done = 0;
    wire sda_w = sda_h & (sda_oe_n | sda_o); // open drain, pull-up
    always #25 clk = ~clk;
    bdcr_i2c_host host (.clk(clk), .sda_in(sda_w), .scl(scl), .sda_h(sda_h));
    bdcr_top #(.IDLE_TIMEOUT(TO)) dut (.clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .pwm_i(pwm), .string_enable(string_enable),
        .string_level(string_level), .cfg(cfg));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    // n input periods, strings checked at each phase end if chk
    task automatic pwm_run(input int n, input int hi, input int per, input logic chk,
                           input logic [5:0] on_hi, input logic [5:0] on_lo);
        repeat (n) begin
            pwm = 1'b1;
            repeat (hi) @(negedge clk);
            if (chk) check("on high", string_enable, on_hi);
            pwm = 1'b0;
            repeat (per - hi) @(negedge clk);
            if (chk) check("on low", string_enable, on_lo);
        end
    endtask : pwm_run
    // write dimming control, unassigned bit zero
    task automatic set_ctrl(input logic [7:0] v);
        logic nak;
        host.wr(I2C_ADDR, 8'h00, {v}, nak);
        check("write ack", nak, 1'b0);
    endtask : set_ctrl
    // watchdog: a hang fails
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
    initial begin
        logic [7:0] q[$];
        logic nak;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        check("mode", cfg.dim_mode, 3'h3);
        check("threshold", cfg.change_duty_25, 1'b1);
        host.rd(8'h00, 12, q);
        foreach (q[i]) check("reset reg", q[i], EXP_RST[i]);
        host.rd(8'hFF, 2, q); // pointer wraps
        check("nvm reg", q[0], 8'h00);
        check("wrap reg", q[1], 8'h6B);
        host.rd(8'h0C, 1, q);
        check("unmapped", q[0], 8'h00);
        host.wr(7'h3D, 8'h00, {8'h00}, nak);
        check("foreign addr", nak, 1'b1);
        host.wr(I2C_ADDR, 8'h00, {8'h04, 8'h1C, 8'hFF}, nak);
        check("burst ack", nak, 1'b0);
        check("dc mode", cfg.dim_mode, 3'h4);
        check("boost freq", cfg.boost_freq, 4'hC);
        check("ilim", cfg.current_limit_high, 1'b1);
        check("full scale", cfg.full_scale, 8'hFF);
        host.rd(8'h01, 2, q);
        check("readback", {q[0], q[1]}, 16'h1CFF);
        // dc: 25 percent duty lands two periods later
        pwm_run(2, 100, 400, 1'b0, 6'h00, 6'h00);
        check("dc early", string_level, 12'h000);
        pwm_run(1, 100, 400, 1'b0, 6'h00, 6'h00);
        check("dc level", string_level, 12'h400);
        pwm_run(2, 200, 400, 1'b1, 6'h3F, 6'h3F);
        check("dc hold", string_level, 12'h400);
        pwm_run(1, 200, 400, 1'b0, 6'h00, 6'h00);
        check("dc new", string_level, 12'h800);
        // mixed, 25 percent threshold: 12.5 percent duty is quarter pwm
        set_ctrl(8'h0A);
        pwm_run(1, 50, 400, 1'b0, 6'h00, 6'h00);
        pwm_run(2, 50, 400, 1'b1, 6'h3F, 6'h00);
        check("mixed low", string_level, 12'h400);
        // mixed, 12.5 percent threshold: same duty now scales amplitude
        set_ctrl(8'h02);
        pwm_run(3, 50, 400, 1'b0, 6'h00, 6'h00);
        pwm_run(1, 50, 400, 1'b1, 6'h3F, 6'h3F);
        check("mixed amp", string_level, 12'h200);
        // direct pwm follows the input at its own rate
        set_ctrl(8'h00);
        pwm_run(3, 30, 100, 1'b1, 6'h3F, 6'h00);
        check("direct level", string_level, 12'hFFF);
        print_verdict();
    end
endmodule : bdcr_top_tb
